// File: inc/mpct_defines.vh
// Register map, field positions, modes and reset values of the timer
`ifndef MPCT_DEFINES_VH
`define MPCT_DEFINES_VH

`define MPCT_OFF_CTRL     8'h00
`define MPCT_OFF_PRESC    8'h04
`define MPCT_OFF_RELOAD   8'h08
`define MPCT_OFF_COUNT    8'h0C
`define MPCT_OFF_STATUS   8'h10
`define MPCT_OFF_CLEAR    8'h14
`define MPCT_OFF_IRQ_EN   8'h18
`define MPCT_OFF_DMA_EN   8'h1C
`define MPCT_OFF_CHMODE   8'h20
`define MPCT_OFF_DEADTIME 8'h24
`define MPCT_OFF_CMP0     8'h28
`define MPCT_OFF_CMP1     8'h2C
`define MPCT_OFF_CMP2     8'h30
`define MPCT_OFF_CMP3     8'h34

`define MPCT_CTRL_W       10
`define MPCT_CTRL_EN      0
`define MPCT_CTRL_DIR_LO  1
`define MPCT_CTRL_DIR_HI  2
`define MPCT_CTRL_OPM     3
`define MPCT_CTRL_FREEZE  4
`define MPCT_CTRL_SLV_LO  5
`define MPCT_CTRL_SLV_HI  6
`define MPCT_CTRL_TSEL    7
`define MPCT_CTRL_ENC     8
`define MPCT_CTRL_HALL    9
`define MPCT_DT_MOE       8

`define MPCT_DIR_UP       2'h0
`define MPCT_DIR_DOWN     2'h1
`define MPCT_DIR_CENTER   2'h2

`define MPCT_SLV_OFF      2'h0
`define MPCT_SLV_START    2'h1
`define MPCT_SLV_RESET    2'h2
`define MPCT_SLV_GATE     2'h3

`define MPCT_CH_FROZEN    3'h0
`define MPCT_CH_CAP_RISE  3'h1
`define MPCT_CH_CAP_FALL  3'h2
`define MPCT_CH_TOGGLE    3'h3
`define MPCT_CH_PWM1      3'h4
`define MPCT_CH_PWM2      3'h5
`define MPCT_CH_FORCE_LO  3'h6
`define MPCT_CH_FORCE_HI  3'h7

`define MPCT_VAR_MOTOR    0
`define MPCT_VAR_WIDE     1
`define MPCT_VAR_NARROW   2
`define MPCT_VAR_PLAIN1   3
`define MPCT_VAR_DUAL     4
`define MPCT_VAR_COMP_A   5
`define MPCT_VAR_COMP_B   6
`define MPCT_VAR_BASIC    7

`define MPCT_MASK16       32'h0000_FFFF
`define MPCT_MASK32       32'hFFFF_FFFF
`define MPCT_RST_PRESC    16'h0000
`define MPCT_RST_RELOAD   32'h0000_FFFF
`define MPCT_RST_ZERO     32'h0000_0000

`endif

// File: design/mpct_channel.v
// One capture/compare channel: capture, compare, PWM and forced output
`timescale 1ns/1ns
`include "mpct_defines.vh"

module mpct_channel (
    input wire clock,
    input wire srst,
    input wire active,
    input wire tick,
    input wire [31:0] cnt,
    input wire [31:0] cmp,
    input wire [2:0] mode,
    input wire cap_in,
    output reg oc,
    output reg cap_evt,
    output reg match_evt
);
    reg cap_prev;
    wire rise = cap_in & ~cap_prev;
    wire fall = ~cap_in & cap_prev;
    wire hit = tick & (cnt == cmp);

    always @(posedge clock)
    begin
        if (srst)
        begin
            oc <= 1'b0;
            cap_prev <= 1'b0;
            cap_evt <= 1'b0;
            match_evt <= 1'b0;
        end
        else
        begin
            cap_prev <= cap_in;
            cap_evt <= active & (((mode == `MPCT_CH_CAP_RISE) & rise) | ((mode == `MPCT_CH_CAP_FALL) & fall));
            match_evt <= active & hit & (mode[2] | (mode == `MPCT_CH_TOGGLE) | (mode == `MPCT_CH_FROZEN));
            if (!active)
                oc <= 1'b0;
            else
            begin
                case (mode)
                    `MPCT_CH_TOGGLE: oc <= hit ? ~oc : oc;
                    // PWM1: compare above reload gives 100 %, zero gives 0 %; PWM2 gives the reverse
                    `MPCT_CH_PWM1: oc <= (cnt < cmp); // RQ5 RQ7
                    `MPCT_CH_PWM2: oc <= ~(cnt < cmp); // RQ5 RQ7
                    `MPCT_CH_FORCE_LO: oc <= 1'b0;
                    `MPCT_CH_FORCE_HI: oc <= 1'b1;
                    default: oc <= 1'b0;
                endcase
            end
        end
    end
endmodule // mpct_channel

// File: design/mpct_deadtime.v
// Complementary output pair with dead time inserted on every edge
`timescale 1ns/1ns

module mpct_deadtime (
    input wire clock,
    input wire srst,
    input wire enable,
    input wire ref_in,
    input wire [7:0] dead,
    output reg out_p,
    output reg out_n
);
    reg ref_prev;
    reg [7:0] wait_cnt;

    always @(posedge clock)
    begin
        if (srst)
        begin
            ref_prev <= 1'b0;
            wait_cnt <= 8'h00;
            out_p <= 1'b0;
            out_n <= 1'b0;
        end
        else if (ref_in != ref_prev)
        begin
            // Both sides off before the other one turns on
            ref_prev <= ref_in;
            wait_cnt <= dead;
            out_p <= 1'b0; // RQ6
            out_n <= 1'b0; // RQ6
        end
        else if (wait_cnt != 8'h00)
            wait_cnt <= wait_cnt - 8'h01;
        else
        begin
            out_p <= enable & ref_prev;
            out_n <= enable & ~ref_prev;
        end
    end
endmodule // mpct_deadtime

// File: design/mpct_timer.v
// Configurable capture/compare/PWM timer with AHB-Lite register slave
//
// Behaviour
// (RQ1) Widest variant 32-bit counter, others 16-bit
// (RQ2) 16-bit prescaler divides by 1 to 65536
// (RQ3) Full variants up/down/center; others up only
// (RQ4) Four channels: capture, compare, PWM, one-pulse
// (RQ5) PWM edge-aligned or center-aligned per timer
// (RQ6) Motor variant: complementary pairs with dead time
// (RQ7) Motor PWM duty from 0 to 100 %
// (RQ8) Debug halt freezes counter when enabled
// (RQ9) Trigger outputs and inputs chain timers together
// (RQ10) Four-channel variants raise own DMA requests
// (RQ11) General four-channel variants decode quadrature encoders
// (RQ12) General variants capture one to three hall sensors
// (RQ13) Single plain variant: one channel, no DMA
// (RQ14) Dual variant: two channels, one complementary output
// (RQ15) Dual and single-comp variants: complementary, own DMA
// (RQ16) Basic variant: 16-bit up time base, no channels
// (RQ17) Trigger output drives converter conversion trigger
// (RQ18) Reload at limit raises update flag; in encoder mode the counter wraps without one
// (RQ19) Channel capture or match sets flag, IRQ, DMA
`timescale 1ns/1ns
`include "mpct_defines.vh"

module mpct_timer #(
    parameter VARIANT = `MPCT_VAR_MOTOR
) (
    input wire clock,
    input wire srst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire dbg_halt,
    input wire [1:0] trig_in,
    input wire [3:0] cap_in,
    output wire [3:0] ch_out,
    output wire [2:0] ch_out_n,
    output reg trig_out,
    output reg dac_trig,
    output reg [4:0] dma_req,
    output reg irq
);
    localparam [5:0] CNT_W = (VARIANT == `MPCT_VAR_WIDE) ? 6'd32 : 6'd16; // RQ1
    localparam [2:0] NUM_CH = (VARIANT <= `MPCT_VAR_NARROW) ? 3'd4 : // RQ4
        (VARIANT == `MPCT_VAR_DUAL) ? 3'd2 : // RQ14
        (VARIANT == `MPCT_VAR_BASIC) ? 3'd0 : 3'd1; // RQ13 RQ16
    localparam [1:0] NUM_N = (VARIANT == `MPCT_VAR_MOTOR) ? 2'd3 : // RQ6
        ((VARIANT >= `MPCT_VAR_DUAL) && (VARIANT <= `MPCT_VAR_COMP_B)) ? 2'd1 : 2'd0; // RQ15
    localparam HAS_UD = (VARIANT <= `MPCT_VAR_NARROW);
    localparam HAS_DMA = (VARIANT != `MPCT_VAR_PLAIN1);
    localparam HAS_ENC = (VARIANT == `MPCT_VAR_WIDE) || (VARIANT == `MPCT_VAR_NARROW);
    localparam [31:0] CNT_MASK = (CNT_W == 6'd32) ? `MPCT_MASK32 : `MPCT_MASK16;

    reg [`MPCT_CTRL_W-1:0] ctrl;
    reg [15:0] presc;
    reg [31:0] reload;
    reg [31:0] cnt;
    reg [4:0] status;
    reg [4:0] irq_en;
    reg [4:0] dma_en;
    reg [15:0] chmode;
    reg [8:0] deadtime;
    reg [31:0] cmp [0:3];
    reg [15:0] psc_cnt;
    reg dir_down;
    reg trig_prev;
    reg enc_a;
    reg enc_b;
    reg ap_valid;
    reg ap_write;
    reg [7:0] ap_addr;

    wire [3:0] oc;
    wire [3:0] cap_evt;
    wire [3:0] match_evt;
    wire [2:0] dt_p;
    wire [2:0] dt_n;

    // Mode decode, reduced to what each variant has
    wire [1:0] dir_mode = HAS_UD ? ctrl[`MPCT_CTRL_DIR_HI:`MPCT_CTRL_DIR_LO] : `MPCT_DIR_UP; // RQ3
    wire [1:0] slave = ctrl[`MPCT_CTRL_SLV_HI:`MPCT_CTRL_SLV_LO];
    wire enc_mode = HAS_ENC & ctrl[`MPCT_CTRL_ENC];
    wire hall_mode = HAS_ENC & ctrl[`MPCT_CTRL_HALL];
    wire trig_sel = ctrl[`MPCT_CTRL_TSEL] ? trig_in[1] : trig_in[0];
    wire trig_rise = trig_sel & ~trig_prev; // RQ9
    wire gate_ok = (slave != `MPCT_SLV_GATE) | trig_sel; // RQ9
    wire run = ctrl[`MPCT_CTRL_EN] & gate_ok & ~(dbg_halt & ctrl[`MPCT_CTRL_FREEZE]); // RQ8
    wire tick = run & ~enc_mode & (psc_cnt == presc); // RQ2
    wire at_top = (cnt >= reload);
    wire at_zero = (cnt == `MPCT_RST_ZERO);
    wire uev = tick & (((dir_mode == `MPCT_DIR_UP) & at_top) | ((dir_mode == `MPCT_DIR_DOWN) & at_zero) |
        ((dir_mode == `MPCT_DIR_CENTER) & ((~dir_down & at_top) | (dir_down & at_zero)))); // RQ18

    // Quadrature decoding on channel 0 and 1 inputs
    wire enc_step = run & enc_mode & ((cap_in[0] != enc_a) | (cap_in[1] != enc_b));
    wire enc_up = enc_a ^ cap_in[1]; // RQ11
    wire [3:0] cap_src = {cap_in[3:1], hall_mode ? (cap_in[0] ^ cap_in[1] ^ cap_in[2]) : cap_in[0]}; // RQ12

    // Bus decode
    wire ap_take = hsel & htrans[1] & hready;
    wire dp_wr = ap_valid & ap_write;
    wire [31:0] wdata_cnt = hwdata & CNT_MASK;
    wire [4:0] clr = (dp_wr && ap_addr == `MPCT_OFF_CLEAR) ? hwdata[4:0] : 5'h00;
    wire [4:0] ch_exist = {(NUM_CH > 3'd3), (NUM_CH > 3'd2), (NUM_CH > 3'd1), (NUM_CH > 3'd0), 1'b1};
    wire [4:0] events = {cap_evt | match_evt, uev} & ch_exist;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_ch
            mpct_channel u_ch (
                .clock(clock),
                .srst(srst),
                .active(gi < NUM_CH), // RQ4 RQ13 RQ14 RQ16
                .tick(tick | enc_step),
                .cnt(cnt),
                .cmp(cmp[gi]),
                .mode(chmode[gi*4+2:gi*4]),
                .cap_in(cap_src[gi]),
                .oc(oc[gi]),
                .cap_evt(cap_evt[gi]),
                .match_evt(match_evt[gi])
            );
        end
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_dt
            mpct_deadtime u_dt (
                .clock(clock),
                .srst(srst),
                .enable((gi < NUM_N) & deadtime[`MPCT_DT_MOE]),
                .ref_in(oc[gi]),
                .dead(deadtime[7:0]),
                .out_p(dt_p[gi]),
                .out_n(dt_n[gi])
            );
            assign ch_out[gi] = (gi < NUM_N) ? dt_p[gi] : oc[gi]; // RQ6 RQ14 RQ15
            assign ch_out_n[gi] = dt_n[gi];
        end
    endgenerate
    assign ch_out[3] = oc[3];

    function [31:0] read_mux;
        input [7:0] addr;
        begin
            case (addr)
                `MPCT_OFF_CTRL: read_mux = {22'h00_0000, ctrl};
                `MPCT_OFF_PRESC: read_mux = {16'h0000, presc};
                `MPCT_OFF_RELOAD: read_mux = reload;
                `MPCT_OFF_COUNT: read_mux = cnt;
                `MPCT_OFF_STATUS: read_mux = {27'h000_0000, status};
                `MPCT_OFF_IRQ_EN: read_mux = {27'h000_0000, irq_en};
                `MPCT_OFF_DMA_EN: read_mux = {27'h000_0000, dma_en};
                `MPCT_OFF_CHMODE: read_mux = {16'h0000, chmode};
                `MPCT_OFF_DEADTIME: read_mux = {23'h00_0000, deadtime};
                `MPCT_OFF_CMP0: read_mux = cmp[0];
                `MPCT_OFF_CMP1: read_mux = cmp[1];
                `MPCT_OFF_CMP2: read_mux = cmp[2];
                `MPCT_OFF_CMP3: read_mux = cmp[3];
                default: read_mux = `MPCT_RST_ZERO;
            endcase
        end
    endfunction

    // AHB-Lite slave, zero wait states, always OKAY
    always @(posedge clock)
    begin
        if (srst)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
            hrdata <= `MPCT_RST_ZERO;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ap_valid <= ap_take;
            ap_write <= ap_take & hwrite;
            ap_addr <= {haddr[7:2], 2'b00};
            if (ap_take & ~hwrite)
                hrdata <= read_mux({haddr[7:2], 2'b00});
        end
    end

    // Software registers, capture loads, sticky flags
    integer k;
    always @(posedge clock)
    begin
        if (srst)
        begin
            ctrl <= {`MPCT_CTRL_W{1'b0}};
            presc <= `MPCT_RST_PRESC;
            reload <= `MPCT_RST_RELOAD & CNT_MASK;
            status <= 5'h00;
            irq_en <= 5'h00;
            dma_en <= 5'h00;
            chmode <= 16'h0000;
            deadtime <= 9'h000;
            for (k = 0; k < 4; k = k + 1)
                cmp[k] <= `MPCT_RST_ZERO;
        end
        else
        begin
            if (dp_wr)
            begin
                case (ap_addr)
                    `MPCT_OFF_CTRL: ctrl <= hwdata[`MPCT_CTRL_W-1:0];
                    `MPCT_OFF_PRESC: presc <= hwdata[15:0];
                    `MPCT_OFF_RELOAD: reload <= wdata_cnt;
                    `MPCT_OFF_IRQ_EN: irq_en <= hwdata[4:0];
                    `MPCT_OFF_DMA_EN: dma_en <= hwdata[4:0];
                    `MPCT_OFF_CHMODE: chmode <= hwdata[15:0];
                    `MPCT_OFF_DEADTIME: deadtime <= hwdata[8:0];
                    `MPCT_OFF_CMP0: cmp[0] <= wdata_cnt;
                    `MPCT_OFF_CMP1: cmp[1] <= wdata_cnt;
                    `MPCT_OFF_CMP2: cmp[2] <= wdata_cnt;
                    `MPCT_OFF_CMP3: cmp[3] <= wdata_cnt;
                    default: ;
                endcase
            end
            // Hardware start and one-pulse stop override a same-cycle write
            if (slave == `MPCT_SLV_START && trig_rise)
                ctrl[`MPCT_CTRL_EN] <= 1'b1; // RQ9
            if (uev && ctrl[`MPCT_CTRL_OPM])
                ctrl[`MPCT_CTRL_EN] <= 1'b0; // RQ4
            for (k = 0; k < 4; k = k + 1)
                if (cap_evt[k])
                    cmp[k] <= cnt; // RQ19
            status <= (status & ~clr) | events; // RQ18 RQ19
        end
    end

    // Prescaler and counter
    always @(posedge clock)
    begin
        if (srst)
        begin
            cnt <= `MPCT_RST_ZERO;
            psc_cnt <= 16'h0000;
            dir_down <= 1'b0;
            trig_prev <= 1'b0;
            enc_a <= 1'b0;
            enc_b <= 1'b0;
        end
        else
        begin
            trig_prev <= trig_sel;
            enc_a <= cap_in[0];
            enc_b <= cap_in[1];
            if (dp_wr && ap_addr == `MPCT_OFF_COUNT)
                cnt <= wdata_cnt;
            else if (slave == `MPCT_SLV_RESET && trig_rise)
            begin
                cnt <= `MPCT_RST_ZERO; // RQ9
                psc_cnt <= 16'h0000;
            end
            else if (enc_step)
            begin
                if (enc_up)
                    cnt <= at_top ? `MPCT_RST_ZERO : ((cnt + 32'h0000_0001) & CNT_MASK); // RQ11
                else
                    cnt <= at_zero ? reload : (cnt - 32'h0000_0001); // RQ11
            end
            else if (run & ~enc_mode)
            begin
                psc_cnt <= tick ? 16'h0000 : (psc_cnt + 16'h0001); // RQ2
                if (tick)
                begin
                    case (dir_mode)
                        `MPCT_DIR_UP: cnt <= at_top ? `MPCT_RST_ZERO : ((cnt + 32'h0000_0001) & CNT_MASK); // RQ18
                        `MPCT_DIR_DOWN: cnt <= at_zero ? reload : (cnt - 32'h0000_0001); // RQ18 RQ3
                        `MPCT_DIR_CENTER:
                        begin
                            // Turn around at both ends
                            if (reload == `MPCT_RST_ZERO)
                                cnt <= `MPCT_RST_ZERO;
                            else if (!dir_down && at_top)
                            begin
                                dir_down <= 1'b1; // RQ3 RQ5
                                cnt <= reload - 32'h0000_0001;
                            end
                            else if (dir_down && at_zero)
                            begin
                                dir_down <= 1'b0; // RQ3 RQ5
                                cnt <= 32'h0000_0001;
                            end
                            else
                                cnt <= dir_down ? (cnt - 32'h0000_0001) : (cnt + 32'h0000_0001);
                        end
                        default: cnt <= cnt;
                    endcase
                end
            end
        end
    end

    // Outputs toward other timers, converter, DMA and interrupt
    always @(posedge clock)
    begin
        if (srst)
        begin
            trig_out <= 1'b0;
            dac_trig <= 1'b0;
            dma_req <= 5'h00;
            irq <= 1'b0;
        end
        else
        begin
            trig_out <= uev; // RQ9
            dac_trig <= uev; // RQ16 RQ17
            dma_req <= HAS_DMA ? (status & dma_en) : 5'h00; // RQ10 RQ13 RQ15 RQ19
            irq <= |(status & irq_en); // RQ19
        end
    end
endmodule // mpct_timer

// File: tb/mpct_timer_monitor.sv
// Port-level checker for the timer, bound to every instance
`timescale 1ns/1ns
`include "mpct_defines.vh"
module mpct_timer_monitor #(
    parameter VARIANT = 0
) (
    input wire clock,
    input wire srst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire dbg_halt,
    input wire [3:0] ch_out,
    input wire [2:0] ch_out_n,
    input wire trig_out,
    input wire dac_trig,
    input wire [4:0] dma_req,
    input wire irq
);
    wire take = hsel && htrans[1] && hready;
    reg wp;
    reg [7:0] wa;
    reg frz;
    reg [4:0] ien;
    reg [4:0] den;
    // Shadow of freeze, interrupt and request enables
    always @(posedge clock)
    begin
        wp <= take && hwrite && !srst;
        wa <= haddr[7:0];
        if (srst)
        begin
            frz <= 1'b0;
            ien <= 5'h00;
            den <= 5'h00;
        end
        else if (wp)
        begin
            if (wa == `MPCT_OFF_CTRL)
                frz <= hwdata[`MPCT_CTRL_FREEZE];
            if (wa == `MPCT_OFF_IRQ_EN)
                ien <= hwdata[4:0];
            if (wa == `MPCT_OFF_DMA_EN)
                den <= hwdata[4:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    property p_trig_dac;
        dac_trig == trig_out;
    endproperty
    a_trig_dac: assert property (p_trig_dac) else $error("converter trigger differs");
    property p_dt_excl;
        (ch_out[2:0] & ch_out_n) == 3'h0;
    endproperty
    a_dt_excl: assert property (p_dt_excl) else $error("both sides of a pair high");
    property p_dt_gap;
        $rose(ch_out_n[0]) |-> !$past(ch_out[0]);
    endproperty
    a_dt_gap: assert property (p_dt_gap) else $error("no dead time before complement");
    property p_cnt16;
        (take && !hwrite && haddr[7:0] == `MPCT_OFF_COUNT && VARIANT != 1) |=> hrdata[31:16] == 16'h0000;
    endproperty
    a_cnt16: assert property (p_cnt16) else $error("counter wider than 16 bits");
    property p_presc16;
        (take && !hwrite && haddr[7:0] == `MPCT_OFF_PRESC) |=> hrdata[31:16] == 16'h0000;
    endproperty
    a_presc16: assert property (p_presc16) else $error("prescaler wider than 16 bits");
    property p_freeze;
        ($past(frz) && $past(dbg_halt)) |-> !trig_out;
    endproperty
    a_freeze: assert property (p_freeze) else $error("update while frozen");
    property p_irq_mask;
        ($past(ien) == 5'h00) |-> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt with no enable");
    property p_dma_mask;
        (dma_req & ~$past(den)) == 5'h00;
    endproperty
    a_dma_mask: assert property (p_dma_mask) else $error("request not enabled");
endmodule // mpct_timer_monitor

bind mpct_timer mpct_timer_monitor #(.VARIANT(VARIANT)) u_mon (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .dbg_halt(dbg_halt), .ch_out(ch_out),
    .ch_out_n(ch_out_n), .trig_out(trig_out), .dac_trig(dac_trig), .dma_req(dma_req), .irq(irq)
);

// File: tb/mpct_load.sv
// Far-side model: encoder lines, capture sources and PWM load
`timescale 1ns/1ns
module mpct_load (
    input wire clock,
    input wire [3:0] ch_out,
    input wire [2:0] ch_out_n,
    output reg [3:0] cap_in
);
    reg [1:0] ph = 2'h0;
    initial cap_in = 4'h0;
    // Up order of lines A,B is 00, 01, 11, 10
    task step(input logic up);
    begin
        @(posedge clock);
        ph = up ? ph + 2'h1 : ph - 2'h1;
        cap_in[1:0] <= {ph[1] ^ ph[0], ph[1]};
        repeat (2) @(posedge clock);
    end
    endtask
    // Low, high, low: one rising edge whatever the old level
    task pulse(input integer b);
    begin
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clock);
            cap_in[b] <= k[0];
            repeat (2) @(posedge clock);
        end
    end
    endtask
    task measure(input integer n, output integer hp, output integer hn);
    begin
        hp = 0;
        hn = 0;
        repeat (n)
        begin
            @(posedge clock);
            hp = hp + (ch_out[0] === 1'b1);
            hn = hn + (ch_out_n[0] === 1'b1);
        end
    end
    endtask
endmodule // mpct_load

// File: tb/mpct_timer_tb.sv
// Bus-driven tests of the motor and narrow timer variants
`timescale 1ns/1ns
`include "mpct_defines.vh"
module mpct_timer_tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic dbg_halt = 1'b0;
    logic [1:0] trig_in = 2'h0;
    logic gsel = 1'b0;
    wire hreadyout;
    wire [31:0] hrdata;
    wire [31:0] hrdata_g;
    wire [3:0] cap_in;
    wire [3:0] ch_out;
    wire [2:0] ch_out_n;
    wire trig_out;
    wire [4:0] dma_req;
    wire irq;
    integer n_mismatch = 0;
    integer comparisons = 0;
    integer c;
    integer hp;
    integer hn;
    integer i;
    logic [31:0] q;
    logic [31:0] r;
    always #2 clock = ~clock;
    mpct_timer #(.VARIANT(`MPCT_VAR_MOTOR)) dut (
        .clock(clock), .srst(srst), .hsel(hsel & ~gsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(), .dbg_halt(dbg_halt), .trig_in(trig_in), .cap_in(cap_in), .ch_out(ch_out),
        .ch_out_n(ch_out_n), .trig_out(trig_out), .dac_trig(), .dma_req(dma_req), .irq(irq)
    );
    // Encoder and hall inputs exist only in the general variants
    mpct_timer #(.VARIANT(`MPCT_VAR_NARROW)) dut_gen (
        .clock(clock), .srst(srst), .hsel(hsel & gsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hrdata(hrdata_g),
        .hresp(), .dbg_halt(dbg_halt), .trig_in(trig_in), .cap_in(cap_in), .ch_out(),
        .ch_out_n(), .trig_out(), .dac_trig(), .dma_req(), .irq()
    );
    mpct_load load (.clock(clock), .ch_out(ch_out), .ch_out_n(ch_out_n), .cap_in(cap_in));
    task conclude;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
    begin
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        q = gsel ? hrdata_g : hrdata;
    end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clock);
    endtask
    // Count change over two back-to-back reads, two cycles apart
    task delta;
    begin
        rd(`MPCT_OFF_COUNT);
        r = q;
        rd(`MPCT_OFF_COUNT);
        q = q - r;
    end
    endtask
    // Cycles between two trigger pulses
    task per;
    begin
        repeat (2)
        begin
            c = 0;
            @(posedge clock);
            while (trig_out !== 1'b1 && c < 200)
            begin
                @(posedge clock);
                c++;
            end
        end
        c++;
    end
    endtask
    task tpulse(input integer b);
    begin
        trig_in[b] <= 1'b1;
        wt(3);
        trig_in <= 2'h0;
        wt(3);
    end
    endtask
    initial
    begin
        wt(3);
        srst <= 1'b0;
        @(posedge clock);
        rd(`MPCT_OFF_RELOAD);
        chk(q, 32'h0000_FFFF);
        rd(8'h40);
        chk(q, 32'h0000_0000);
        wr(`MPCT_OFF_RELOAD, 32'hFFFF_FFFF);
        rd(`MPCT_OFF_RELOAD);
        chk(q, 32'h0000_FFFF);
        wr(`MPCT_OFF_PRESC, 32'hFFFF_FFFF);
        rd(`MPCT_OFF_PRESC);
        chk(q, 32'h0000_FFFF);
        wr(`MPCT_OFF_PRESC, 32'h0000_0002);
        wr(`MPCT_OFF_RELOAD, 32'h0000_0004);
        wr(`MPCT_OFF_CTRL, 32'h0000_0001);
        per();
        chk(c, 15);
        wr(`MPCT_OFF_CTRL, 32'h0000_0000);
        rd(`MPCT_OFF_STATUS);
        chk(q & 32'h0000_0001, 32'h0000_0001);
        wr(`MPCT_OFF_IRQ_EN, 32'h0000_0001);
        wr(`MPCT_OFF_DMA_EN, 32'h0000_0001);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({27'h0, dma_req}, 32'h0000_0001);
        wr(`MPCT_OFF_IRQ_EN, 32'h0000_0000);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`MPCT_OFF_IRQ_EN, 32'h0000_0001);
        wr(`MPCT_OFF_CLEAR, 32'h0000_001F);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`MPCT_OFF_PRESC, 32'h0000_0000);
        wr(`MPCT_OFF_RELOAD, 32'h0000_0028);
        for (i = 0; i < 3; i++)
        begin
            wr(`MPCT_OFF_CTRL, i << 1);
            wr(`MPCT_OFF_COUNT, 32'h0000_0014);
            wr(`MPCT_OFF_CTRL, (i << 1) | 1);
            delta();
            if (i < 2)
                chk(q, i ? 32'hFFFF_FFFE : 32'h0000_0002);
            per();
            chk(c, i == 2 ? 40 : 41);
        end
        wr(`MPCT_OFF_CTRL, 32'h0000_0009);
        wt(50);
        rd(`MPCT_OFF_CTRL);
        chk(q & 32'h0000_0001, 32'h0000_0000);
        wr(`MPCT_OFF_CTRL, 32'h0000_0011);
        wr(`MPCT_OFF_COUNT, 32'h0000_0014);
        dbg_halt <= 1'b1;
        wt(2);
        delta();
        chk(q, 32'h0000_0000);
        dbg_halt <= 1'b0;
        wt(2);
        delta();
        chk(q, 32'h0000_0002);
        wr(`MPCT_OFF_CTRL, 32'h0000_00A0);
        tpulse(0);
        rd(`MPCT_OFF_CTRL);
        chk(q & 32'h0000_0001, 32'h0000_0000);
        tpulse(1);
        rd(`MPCT_OFF_CTRL);
        chk(q & 32'h0000_0001, 32'h0000_0001);
        gsel <= 1'b1;
        wr(`MPCT_OFF_CTRL, 32'h0000_0101);
        wr(`MPCT_OFF_COUNT, 32'h0000_000A);
        for (i = 0; i < 6; i++)
            load.step(i < 4);
        rd(`MPCT_OFF_COUNT);
        chk(q, 32'h0000_000C);
        wr(`MPCT_OFF_CTRL, 32'h0000_0200);
        wr(`MPCT_OFF_COUNT, 32'h0000_1234);
        wr(`MPCT_OFF_CHMODE, 32'h0000_0011);
        wr(`MPCT_OFF_CLEAR, 32'h0000_001F);
        load.pulse(2);
        load.pulse(1);
        rd(`MPCT_OFF_STATUS);
        chk(q, 32'h0000_0006);
        rd(`MPCT_OFF_CMP0);
        chk(q, 32'h0000_1234);
        rd(`MPCT_OFF_CMP1);
        chk(q, 32'h0000_1234);
        gsel <= 1'b0;
        wr(`MPCT_OFF_CTRL, 32'h0000_0000);
        wr(`MPCT_OFF_RELOAD, 32'h0000_0009);
        wr(`MPCT_OFF_DEADTIME, 32'h0000_0103);
        wr(`MPCT_OFF_CHMODE, 32'h0000_0004);
        wr(`MPCT_OFF_CTRL, 32'h0000_0001);
        for (i = 0; i < 3; i++)
        begin
            wr(`MPCT_OFF_CMP0, i * 5);
            wt(25);
            load.measure(40, hp, hn);
            if (i == 1)
                chk(hp == hn && hp > 0, 1);
            else
                chk(hp, i ? 40 : 0);
        end
        conclude();
    end
    // Whole run needs about 650 cycles
    initial
    begin
        #40000;
        n_mismatch++;
        conclude();
    end
endmodule // mpct_timer_tb
